// [include/agoc_cfg.svh]
// register map, field layout and reset values of the auxiliary calibration bank
`ifndef AGOC_CFG_SVH
`define AGOC_CFG_SVH

`define AGOC_ADDR_W 14
`define AGOC_DATA_W 32
`define AGOC_RES_W 16
`define AGOC_FIELD_W 15
`define AGOC_FRAC_W 14
`define AGOC_QUARTER_SH 2

`define AGOC_OFF_GAIN_X4 14'h2278
`define AGOC_OFF_GAIN_X9 14'h2298
`define AGOC_OFF_OFFS_X9 14'h22d0
`define AGOC_OFF_OFFS_X4 14'h22d4
`define AGOC_OFF_STATUS 14'h2300
`define AGOC_OFF_COUNT 14'h2304

`define AGOC_RST_GAIN 15'h4000
`define AGOC_RST_OFFS 15'h0000
`define AGOC_RST_WORD 32'h0000_0000

`define AGOC_ST_RES_LSB 0
`define AGOC_ST_PAIR_LSB 16
`define AGOC_ST_ILL_BIT 18
`define AGOC_ST_SAT_BIT 19

`endif

// [include/agoc_pkg.sv]
// types shared by the auxiliary calibration bank
package agoc_pkg;

  // amplifier gain setting as reported by the analog front end
  typedef enum logic [2:0] {
    AGOC_AMP_X1,
    AGOC_AMP_X1P5,
    AGOC_AMP_X2,
    AGOC_AMP_X4,
    AGOC_AMP_X9
  } agoc_amp_gain_t;

  // which calibration pair corrects a sample
  typedef enum logic [1:0] {
    AGOC_PAIR_NONE,
    AGOC_PAIR_X4,
    AGOC_PAIR_X9
  } agoc_pair_t;

endpackage : agoc_pkg

// [src/agoc_cal_bank.sv]
// auxiliary channel gain/offset calibration bank with register port
// Notes on behaviour
// - offset field is 15-bit two's complement
// - offset code one adds a quarter LSB
// - zero offset leaves result unchanged; reset value
// - first offset register serves amplifier gain nine
// - second offset register serves amplifier gain four
// - gain field low fifteen bits, fourteen fractional
// - gain code 0x4000 is unity; reset value
// - gain code zero forces result zero
// - 0x2000 halves the result, 0x7fff scales it by 32767/16384, just under two
// - 0x4001 scales one step above unity
// - 0x0001 and 0x3fff scale below unity
// - gain-four pair skips transimpedance and temperature
// - gain-nine pair serves auxiliary voltage inputs
// - bits 31 to 15 read zero, read-only
// - offset registers reset to zero
// - one offset step is quarter result LSB
`timescale 1ns/1ps
`include "agoc_cfg.svh"

module agoc_cal_bank
  import agoc_pkg::*;
#(
  parameter int ADDR_W = `AGOC_ADDR_W,
  parameter int DATA_W = `AGOC_DATA_W,
  parameter int RES_W = `AGOC_RES_W,
  parameter int CAL_W = `AGOC_FIELD_W
)
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [DATA_W-1:0] regRdData,
  input wire logic [RES_W-1:0] convResult,
  input wire logic convValid,
  input wire agoc_amp_gain_t inputAmpGain,
  input wire logic chanIsTransimpedance,
  input wire logic chanIsTempSensor,
  output logic [RES_W-1:0] convResultWord,
  output logic convResultValid,
  output agoc_pair_t corrPairUsed
);

  // calibration registers
  logic [CAL_W-1:0] gainX4_r;
  logic [CAL_W-1:0] gainX4_nxt;
  logic [CAL_W-1:0] gainX9_r;
  logic [CAL_W-1:0] gainX9_nxt;
  logic [CAL_W-1:0] offsX4_r;
  logic [CAL_W-1:0] offsX4_nxt;
  logic [CAL_W-1:0] offsX9_r;
  logic [CAL_W-1:0] offsX9_nxt;

  // read port
  logic [DATA_W-1:0] rdData_r;
  logic [DATA_W-1:0] rdData_nxt;

  // correction datapath
  logic [RES_W-1:0] result_r;
  logic [RES_W-1:0] result_nxt;
  logic resultValid_r;
  logic resultValid_nxt;
  agoc_pair_t pairUsed_r;
  agoc_pair_t pairUsed_nxt;
  logic illegalSeen_r;
  logic illegalSeen_nxt;
  logic satSeen_r;
  logic satSeen_nxt;
  logic [RES_W-1:0] sampleCount_r;
  logic [RES_W-1:0] sampleCount_nxt;

  agoc_pair_t pairSel;
  logic [CAL_W-1:0] selOffs;
  logic [CAL_W-1:0] selGain;
  logic selBypass;
  logic [RES_W-1:0] corrValue;
  logic corrIllegal;
  logic corrSat;
  logic isAuxChannel;
  logic [DATA_W-1:0] statusWord;

  // register writes; only the value field is stored
  always_comb
  begin
    gainX4_nxt = gainX4_r;
    gainX9_nxt = gainX9_r;
    offsX4_nxt = offsX4_r;
    offsX9_nxt = offsX9_r;
    if (regWrStb)
    begin
      case (regAddr)
        `AGOC_OFF_GAIN_X4: gainX4_nxt = regWrData[CAL_W-1:0];
        `AGOC_OFF_GAIN_X9: gainX9_nxt = regWrData[CAL_W-1:0];
        `AGOC_OFF_OFFS_X4: offsX4_nxt = regWrData[CAL_W-1:0];
        `AGOC_OFF_OFFS_X9: offsX9_nxt = regWrData[CAL_W-1:0];
        default:
        begin
          // read-only and unmapped addresses drop writes
          gainX4_nxt = gainX4_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      gainX4_r <= `AGOC_RST_GAIN;
      gainX9_r <= `AGOC_RST_GAIN;
      offsX4_r <= `AGOC_RST_OFFS;
      offsX9_r <= `AGOC_RST_OFFS;
    end
    else
    begin
      gainX4_r <= gainX4_nxt;
      gainX9_r <= gainX9_nxt;
      offsX4_r <= offsX4_nxt;
      offsX9_r <= offsX9_nxt;
    end
  end

  // status layout kept in one place; a live view, nothing here is sticky
  always_comb
  begin
    statusWord = `AGOC_RST_WORD;
    statusWord[`AGOC_ST_RES_LSB +: RES_W] = result_r;
    statusWord[`AGOC_ST_PAIR_LSB +: $bits(agoc_pair_t)] = pairUsed_r;
    statusWord[`AGOC_ST_ILL_BIT] = illegalSeen_r;
    statusWord[`AGOC_ST_SAT_BIT] = satSeen_r;
  end

  // read data lands one cycle after the strobe and only then
  always_comb
  begin
    rdData_nxt = `AGOC_RST_WORD;
    if (regRdStb)
    begin
      case (regAddr)
        `AGOC_OFF_GAIN_X4: rdData_nxt = DATA_W'(gainX4_r);
        `AGOC_OFF_GAIN_X9: rdData_nxt = DATA_W'(gainX9_r);
        `AGOC_OFF_OFFS_X4: rdData_nxt = DATA_W'(offsX4_r);
        `AGOC_OFF_OFFS_X9: rdData_nxt = DATA_W'(offsX9_r);
        `AGOC_OFF_STATUS: rdData_nxt = statusWord;
        `AGOC_OFF_COUNT: rdData_nxt = DATA_W'(sampleCount_r);
        default:
        begin
          // unmapped addresses read zero
          rdData_nxt = `AGOC_RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      rdData_r <= `AGOC_RST_WORD;
    end
    else
    begin
      rdData_r <= rdData_nxt;
    end
  end

  // pair selection from amplifier gain and channel class
  always_comb
  begin
    isAuxChannel = !chanIsTransimpedance && !chanIsTempSensor;
    pairSel = AGOC_PAIR_NONE;
    selOffs = `AGOC_RST_OFFS;
    selGain = `AGOC_RST_GAIN;
    case (inputAmpGain)
      AGOC_AMP_X4:
      begin
        if (isAuxChannel)
        begin
          pairSel = AGOC_PAIR_X4;
          selOffs = offsX4_r;
          selGain = gainX4_r;
        end
      end
      AGOC_AMP_X9:
      begin
        if (isAuxChannel)
        begin
          pairSel = AGOC_PAIR_X9;
          selOffs = offsX9_r;
          selGain = gainX9_r;
        end
      end
      default:
      begin
        // other gains and channels are calibrated outside this bank
        pairSel = AGOC_PAIR_NONE;
      end
    endcase
    selBypass = (pairSel == AGOC_PAIR_NONE);
  end

  agoc_corr_unit #(
    .RES_W(RES_W),
    .CAL_W(CAL_W),
    .FRAC_W(`AGOC_FRAC_W),
    .QSH(`AGOC_QUARTER_SH)
  ) u_corr (
    .resultIn(convResult),
    .offsCode(selOffs),
    .gainCode(selGain),
    .bypass(selBypass),
    .corrOut(corrValue),
    .gainIllegal(corrIllegal),
    .saturated(corrSat)
  );

  // one registered stage: corrected word follows each valid sample
  always_comb
  begin
    result_nxt = result_r;
    resultValid_nxt = 1'b0;
    pairUsed_nxt = pairUsed_r;
    if (convValid)
    begin
      result_nxt = corrValue;
      resultValid_nxt = 1'b1;
      pairUsed_nxt = pairSel;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      result_r <= '0;
      resultValid_r <= 1'b0;
      pairUsed_r <= AGOC_PAIR_NONE;
    end
    else
    begin
      result_r <= result_nxt;
      resultValid_r <= resultValid_nxt;
      pairUsed_r <= pairUsed_nxt;
    end
  end

  // flags describe the latest sample only; not sticky, so no clear race
  always_comb
  begin
    illegalSeen_nxt = illegalSeen_r;
    satSeen_nxt = satSeen_r;
    if (convValid)
    begin
      illegalSeen_nxt = corrIllegal;
      satSeen_nxt = corrSat;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      illegalSeen_r <= 1'b0;
      satSeen_r <= 1'b0;
    end
    else
    begin
      illegalSeen_r <= illegalSeen_nxt;
      satSeen_r <= satSeen_nxt;
    end
  end

  // sample counter wraps silently; software differences two reads
  always_comb
  begin
    sampleCount_nxt = sampleCount_r;
    if (convValid)
    begin
      sampleCount_nxt = sampleCount_r + RES_W'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sampleCount_r <= '0;
    end
    else
    begin
      sampleCount_r <= sampleCount_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign convResultWord = result_r;
  assign convResultValid = resultValid_r;
  assign corrPairUsed = pairUsed_r;

endmodule : agoc_cal_bank

// [src/agoc_corr_unit.sv]
// offset-then-gain correction arithmetic with saturation
`timescale 1ns/1ps
`include "agoc_cfg.svh"

module agoc_corr_unit
  import agoc_pkg::*;
#(
  parameter int RES_W = `AGOC_RES_W,
  parameter int CAL_W = `AGOC_FIELD_W,
  parameter int FRAC_W = `AGOC_FRAC_W,
  parameter int QSH = `AGOC_QUARTER_SH
)
(
  input wire logic [RES_W-1:0] resultIn,
  input wire logic [CAL_W-1:0] offsCode,
  input wire logic [CAL_W-1:0] gainCode,
  input wire logic bypass,
  output logic [RES_W-1:0] corrOut,
  output logic gainIllegal,
  output logic saturated
);

  localparam int SUM_W = RES_W + QSH + 2;
  localparam int PRD_W = SUM_W + CAL_W + 1;
  localparam int SH = FRAC_W + QSH;

  logic signed [SUM_W-1:0] sumQ;
  logic signed [PRD_W-1:0] prodQ;
  logic signed [PRD_W-1:0] shiftQ;
  logic signed [PRD_W-1:0] maxQ;

  always_comb
  begin
    // work in quarter LSBs so one offset step is exact
    sumQ = ($signed(SUM_W'(resultIn)) <<< QSH) + SUM_W'($signed(offsCode));
    // gain field is code / 2^FRAC_W, so 0x4000 is unity
    prodQ = PRD_W'(sumQ) * $signed(PRD_W'({1'b0, gainCode}));
    shiftQ = prodQ >>> SH;
    maxQ = $signed(PRD_W'({RES_W{1'b1}}));
    gainIllegal = !bypass && (gainCode == '0);
    saturated = 1'b0;
    if (bypass)
    begin
      corrOut = resultIn;
    end
    else if (gainCode == '0)
    begin
      corrOut = '0;
    end
    else if (shiftQ < 0)
    begin
      // result word is unsigned; clamp rather than wrap
      corrOut = '0;
      saturated = 1'b1;
    end
    else if (shiftQ > maxQ)
    begin
      corrOut = '1;
      saturated = 1'b1;
    end
    else
    begin
      corrOut = shiftQ[RES_W-1:0];
    end
  end

endmodule : agoc_corr_unit

// [tb/agoc_cal_bank_assertions.sv]
// port-level checks of the auxiliary calibration bank
`timescale 1ns/1ps
`include "agoc_cfg.svh"
module agoc_cal_bank_chk
  import agoc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [`AGOC_ADDR_W-1:0] regAddr,
  input wire logic [`AGOC_DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [`AGOC_DATA_W-1:0] regRdData,
  input wire logic [`AGOC_RES_W-1:0] convResult,
  input wire logic convValid,
  input wire agoc_amp_gain_t inputAmpGain,
  input wire logic chanIsTransimpedance,
  input wire logic chanIsTempSensor,
  input wire logic [`AGOC_RES_W-1:0] convResultWord,
  input wire logic convResultValid,
  input wire agoc_pair_t corrPairUsed
);
  logic calAddr;
  logic plainChan;
  logic [14:0] wrLow;
  assign calAddr = regAddr inside {`AGOC_OFF_GAIN_X4, `AGOC_OFF_GAIN_X9,
    `AGOC_OFF_OFFS_X9, `AGOC_OFF_OFFS_X4};
  assign plainChan = convValid && !chanIsTransimpedance && !chanIsTempSensor;
  assign wrLow = regWrData[14:0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  property p_vld;
    convValid |=> convResultValid;
  endproperty
  property p_idle;
    !convValid |=> !convResultValid && $stable(convResultWord) && $stable(corrPairUsed);
  endproperty
  property p_rdz;
    !regRdStb |=> regRdData == 32'h0;
  endproperty
  property p_rsv;
    regRdStb && calAddr |=> regRdData[31:15] == 17'h0;
  endproperty
  property p_wrrd;
    regWrStb && calAddr ##1 regRdStb && $stable(regAddr) |=> regRdData == {17'h0, $past(wrLow, 2)};
  endproperty
  property p_x4;
    plainChan && inputAmpGain == AGOC_AMP_X4 |=> corrPairUsed == AGOC_PAIR_X4;
  endproperty
  property p_x9;
    plainChan && inputAmpGain == AGOC_AMP_X9 |=> corrPairUsed == AGOC_PAIR_X9;
  endproperty
  property p_byp;
    convValid && !(plainChan && inputAmpGain inside {AGOC_AMP_X4, AGOC_AMP_X9})
      |=> corrPairUsed == AGOC_PAIR_NONE && convResultWord == $past(convResult);
  endproperty
  a_vld: assert property (p_vld) else $error("no result pulse");
  a_idle: assert property (p_idle) else $error("result moved without sample");
  a_rdz: assert property (p_rdz) else $error("read data not cleared");
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  a_wrrd: assert property (p_wrrd) else $error("readback differs");
  a_x4: assert property (p_x4) else $error("gain four pair not used");
  a_x9: assert property (p_x9) else $error("gain nine pair not used");
  a_byp: assert property (p_byp) else $error("uncorrected sample altered");
  c_x4: cover property (plainChan && inputAmpGain == AGOC_AMP_X4);
  c_x9: cover property (plainChan && inputAmpGain == AGOC_AMP_X9);
  c_wrrd: cover property (regWrStb && calAddr ##1 regRdStb);
endmodule : agoc_cal_bank_chk

bind agoc_cal_bank agoc_cal_bank_chk chk_u (.clk_sys, .nrst, .regAddr, .regWrData,
  .regWrStb, .regRdStb, .regRdData, .convResult, .convValid, .inputAmpGain,
  .chanIsTransimpedance, .chanIsTempSensor, .convResultWord, .convResultValid,
  .corrPairUsed);

// [tb/agoc_cal_bank_tb.sv]
// self-checking bench for the auxiliary calibration bank
`timescale 1ns/1ps
`include "agoc_cfg.svh"
module agoc_cal_bank_tb
  import agoc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [13:0] regAddr = 14'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData;
  logic [15:0] convResult = 16'h0;
  logic convValid = 1'b0;
  agoc_amp_gain_t inputAmpGain = AGOC_AMP_X1;
  logic chanIsTransimpedance = 1'b0;
  logic chanIsTempSensor = 1'b0;
  logic [15:0] convResultWord;
  logic convResultValid;
  agoc_pair_t corrPairUsed;
  int numErrors = 0;
  int checksDone = 0;
  int nSmp = 0;
  logic [14:0] gainR [2] = '{15'h4000, 15'h4000};
  logic [14:0] offsR [2] = '{15'h0, 15'h0};
  logic [13:0] gAdr [2] = '{`AGOC_OFF_GAIN_X4, `AGOC_OFF_GAIN_X9};
  logic [13:0] oAdr [2] = '{`AGOC_OFF_OFFS_X4, `AGOC_OFF_OFFS_X9};
  logic [14:0] gTab [7] = '{15'h0, 15'h2000, 15'h7fff, 15'h4001, 15'h1, 15'h3fff, 15'h4000};
  logic [14:0] oTab [5] = '{15'h3fff, 15'h1, 15'h0, 15'h7fff, 15'h4000};

  agoc_cal_bank dut_u (.clk_sys, .nrst, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData, .convResult, .convValid, .inputAmpGain, .chanIsTransimpedance,
    .chanIsTempSensor, .convResultWord, .convResultValid, .corrPairUsed);

  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end

  // offset in quarter steps first, then code/16384, floor and clamp
  function automatic logic [15:0] expw(logic [15:0] r, logic [14:0] o, logic [14:0] g);
    longint q;
    q = ((longint'(r) <<< 2) + longint'($signed(o))) * longint'(g);
    q = q >>> 16;
    if (g == 15'h0) return 16'h0;
    if (q < 0) return 16'h0;
    if (q > 65535) return 16'hffff;
    return q[15:0];
  endfunction : expw

  // {clamped, gain code zero} for a corrected sample
  function automatic logic [1:0] expf(logic [15:0] r, logic [14:0] o, logic [14:0] g);
    longint q;
    q = (((longint'(r) <<< 2) + longint'($signed(o))) * longint'(g)) >>> 16;
    if (g == 15'h0) return 2'b01;
    return {q < 0 || q > 65535, 1'b0};
  endfunction : expf

  task results();
    if (numErrors == 0 && checksDone > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task rd(input logic [13:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rd

  // write, then read back at once; upper bits written as ones
  task wcal(input int i, input logic [14:0] g, input logic [14:0] o);
    gainR[i] = g;
    offsR[i] = o;
    @(posedge clk_sys);
    regWrStb <= 1'b1;
    regAddr <= gAdr[i];
    regWrData <= {17'h1ffff, g};
    rd(gAdr[i], {17'h0, g});
    @(posedge clk_sys);
    regWrStb <= 1'b1;
    regAddr <= oAdr[i];
    regWrData <= {17'h1ffff, o};
    rd(oAdr[i], {17'h0, o});
  endtask : wcal

  task smp(input logic [15:0] r, input agoc_amp_gain_t g, input logic t, input logic s);
    int i;
    logic [15:0] e;
    logic [1:0] f;
    agoc_pair_t p;
    i = (g == AGOC_AMP_X9);
    p = i ? AGOC_PAIR_X9 : AGOC_PAIR_X4;
    e = expw(r, offsR[i], gainR[i]);
    f = expf(r, offsR[i], gainR[i]);
    if (t || s || !(g inside {AGOC_AMP_X4, AGOC_AMP_X9}))
    begin
      p = AGOC_PAIR_NONE;
      e = r;
      f = 2'b00;
    end
    @(posedge clk_sys);
    convValid <= 1'b1;
    convResult <= r;
    inputAmpGain <= g;
    chanIsTransimpedance <= t;
    chanIsTempSensor <= s;
    @(posedge clk_sys);
    convValid <= 1'b0;
    #1 chk(convResultValid, 32'h1);
    chk(convResultWord, e);
    chk(corrPairUsed, p);
    nSmp++;
    // status view of the same sample: {clamped, gain code zero, pair, word}
    rd(`AGOC_OFF_STATUS, {12'h0, f, 2'(p), e});
  endtask : smp

  // called in the step that releases reset; all state must be at defaults
  task rstchk();
    gainR = '{15'h4000, 15'h4000};
    offsR = '{15'h0, 15'h0};
    nSmp = 0;
    #1 chk(convResultWord, 32'h0);
    chk(convResultValid, 32'h0);
    chk(corrPairUsed, AGOC_PAIR_NONE);
    chk(regRdData, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      rd(gAdr[i], 32'h4000);
      rd(oAdr[i], 32'h0);
    end
    rd(`AGOC_OFF_COUNT, 32'h0);
  endtask : rstchk

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    numErrors++;
    results();
  end

  initial
  begin
    void'($urandom(32'h0f34));
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rstchk();
    rd(14'h0, 32'h0);
    smp(16'h1234, AGOC_AMP_X4, 1'b0, 1'b0);
    for (int i = 0; i < 2; i++)
    begin
      for (int k = 0; k < 7; k++)
      begin
        wcal(i, gTab[k], oTab[k % 5]);
        smp(16'h1000, i ? AGOC_AMP_X9 : AGOC_AMP_X4, 1'b0, 1'b0);
        smp(16'($urandom), i ? AGOC_AMP_X9 : AGOC_AMP_X4, 1'b0, 1'b0);
        smp(16'h1000, i ? AGOC_AMP_X9 : AGOC_AMP_X4, 1'b1, 1'b0);
        smp(16'h1000, i ? AGOC_AMP_X9 : AGOC_AMP_X4, 1'b0, 1'b1);
      end
    end
    // mid-run reset must drop every programmed value
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rstchk();
    repeat (150)
    begin
      if ($urandom_range(3) == 0) wcal($urandom_range(1), 15'($urandom), 15'($urandom));
      smp(16'($urandom), agoc_amp_gain_t'(3'($urandom_range(4))),
        $urandom_range(3) == 0, $urandom_range(3) == 0);
    end
    rd(`AGOC_OFF_COUNT, nSmp);
    results();
  end
endmodule : agoc_cal_bank_tb
